/* logic/pll_ctl_pkg.sv */
// package: shared constants for the serial divider control link and device
package pll_ctl_pkg;
    // word layout
    localparam int REF_WORD_BITS = 16;
    localparam int MAIN_WORD_BITS = 19;
    localparam int REF_RATIO_BITS = 14;
    localparam int SWALLOW_BITS = 7;
    localparam int PROG_BITS = 11;
    localparam int REF_LATCH_BITS = 15;
    localparam int MAIN_LATCH_BITS = 18;
    localparam int SHIFT_BITS = 19;
    // field positions inside the shift register (bit 0 is the last bit shifted in)
    localparam int SEL_POS = 0;
    localparam int MOD_POS = 1;
    localparam int RATIO_LSB = 2;
    localparam int SWALLOW_LSB = 1;
    localparam int PROG_LSB = 8;
    // ratio limits
    localparam logic [13:0] REF_RATIO_MIN = 14'h0008;
    localparam logic [10:0] PROG_RATIO_MIN = 11'h010;
    // prescaler moduli
    localparam logic [7:0] MODULUS_LOW = 8'h80;
    localparam logic [7:0] MODULUS_HIGH = 8'h40;
    // reset defaults of the latches (arbitrary, none documented)
    localparam logic [13:0] REF_RATIO_RESET = 14'h0008;
    localparam logic [10:0] PROG_RATIO_RESET = 11'h010;
    localparam logic [6:0] SWALLOW_RESET = 7'h00;
    // controller timing: shift clock half period in system clocks
    localparam int SCLK_HALF = 4;
    localparam logic [3:0] SCLK_HALF_CNT = 4'(SCLK_HALF - 1);
    // controller status/interrupt bits
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_LOCK_BIT = 1;
    localparam int IRQ_UNLOCK_BIT = 2;
    localparam int IRQ_BITS = 3;
    // wishbone register offsets (byte addresses)
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_CTRL = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;
    localparam logic [3:0] ADDR_MASK = 4'hc;
    // controller states
    typedef enum logic [1:0] {IDLE, SHIFT_LOW, SHIFT_HIGH, LOAD} ctl_state_type;
endpackage : pll_ctl_pkg

/* logic/pll_link_if.sv */
// interface: three-wire programming link from controller to device
`timescale 1ns/100ps
interface pll_link_if;
    logic serial_data;       // data bit, valid at shift clock rise
    logic shift_clock;       // shift clock from controller
    logic load_latch_strobe; // copy shift register to latch while high
    modport controller (output serial_data, output shift_clock, output load_latch_strobe);
    modport device (input serial_data, input shift_clock, input load_latch_strobe);
endinterface : pll_link_if

/* logic/pll_divider_device.sv */
// device end: shared shift register, latches, pulse-swallow divider, phase compare
//
// Summary of operation
// - capture one data bit per shift clock rise
// - last bit picks reference or main latch
// - latch copies while strobe high; open counts high
// - fast lock switch follows pump while strobe
// - monitor shows reference or main divider output
// - reference word: ratio, modulus bit, select one
// - reference ratio 8 to 16383, never below 8; the device latches any value
// - modulus bit low 128, high 64
// - main word: N, A, select zero
// - main latch holds 7-bit A, 11-bit N
// - swallow ratio A is 0 to 127
// - programmable ratio N 16 to 2047
// - one output period per P*N+A input cycles
// - software keeps A below N; the controller does not check
// - polarity high output table
// - polarity low output table
// - lock high while dividers in phase
// - reference latch: 14-bit ratio plus modulus bit
`timescale 1ns/100ps
module pll_divider_device
(
    // system
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // link from controller
    pll_link_if.device link,
    // divider clock inputs and polarity select (pins, sampled)
    input wire logic crystal_osc_input_i,
    input wire logic prescaler_input_i,
    input wire logic phase_polarity_select_i,
    // pump outputs, level plus active-low enable, except ref_pump_ctl_o which is level only
    output logic pump_out_o,
    output logic pump_out_oe_n_o,
    output logic ref_pump_ctl_o,
    output logic main_pump_ctl_o,
    output logic main_pump_ctl_oe_n_o,
    output logic fast_lock_switch_out_o,
    output logic fast_lock_switch_out_oe_n_o,
    // monitors
    output logic lock_detect_out_o,
    output logic compare_monitor_out_o,
    output logic ref_divider_out_o,
    output logic main_divider_out_o
);
    // ==========================================================
    // input synchronisers
    // ==========================================================
    logic [5:0] sync1; // first stage, read only by sync2
    logic [5:0] sync2; // second stage
    logic [5:0] pins;  // raw pin vector
    assign pins = {link.serial_data, link.shift_clock, link.load_latch_strobe,
                   crystal_osc_input_i, prescaler_input_i, phase_polarity_select_i};
    // two flops per pin
    always_ff @(posedge clk_sys_i)
    begin
        sync1 <= pins;
        sync2 <= sync1;
    end
    logic data_s, sclk_s, strobe_s, osc_s, pre_s, pol_s;
    assign {data_s, sclk_s, strobe_s, osc_s, pre_s, pol_s} = sync2;
    logic sclk_d, osc_d, pre_d; // edge history
    always_ff @(posedge clk_sys_i)
    begin
        sclk_d <= sclk_s;
        osc_d <= osc_s;
        pre_d <= pre_s;
    end
    logic sclk_rise, osc_rise, pre_rise;
    assign sclk_rise = sclk_s & ~sclk_d;
    assign osc_rise = osc_s & ~osc_d;
    assign pre_rise = pre_s & ~pre_d;
    // ==========================================================
    // shift register and latches
    // ==========================================================
    logic [pll_ctl_pkg::SHIFT_BITS-1:0] shreg; // shared shift register
    // shift one bit per shift clock rise, msb first
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            shreg <= '0;
        else if (sclk_rise)
            shreg <= {shreg[pll_ctl_pkg::SHIFT_BITS-2:0], data_s};
    end
    logic [pll_ctl_pkg::REF_RATIO_BITS-1:0] ref_ratio_latch;
    logic modulus_latch;                                     // high picks 64/65
    logic [pll_ctl_pkg::SWALLOW_BITS-1:0] swallow_latch;
    logic [pll_ctl_pkg::PROG_BITS-1:0] prog_latch;
    // latch copies while strobe high; select bit steers the word
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            ref_ratio_latch <= pll_ctl_pkg::REF_RATIO_RESET;
            modulus_latch <= 1'b0;
            swallow_latch <= pll_ctl_pkg::SWALLOW_RESET;
            prog_latch <= pll_ctl_pkg::PROG_RATIO_RESET;
        end
        else if (strobe_s)
        begin
            if (shreg[pll_ctl_pkg::SEL_POS])
            begin
                ref_ratio_latch <= shreg[pll_ctl_pkg::RATIO_LSB +: pll_ctl_pkg::REF_RATIO_BITS];
                modulus_latch <= shreg[pll_ctl_pkg::MOD_POS];
            end
            else
            begin
                swallow_latch <= shreg[pll_ctl_pkg::SWALLOW_LSB +: pll_ctl_pkg::SWALLOW_BITS];
                prog_latch <= shreg[pll_ctl_pkg::PROG_LSB +: pll_ctl_pkg::PROG_BITS];
            end
        end
    end
    // ==========================================================
    // reference counter
    // ==========================================================
    logic [pll_ctl_pkg::REF_RATIO_BITS-1:0] ref_cnt;
    logic ref_pulse; // one clock at terminal count
    // count oscillator rises, reload latched ratio at terminal count
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            ref_cnt <= pll_ctl_pkg::REF_RATIO_RESET;
            ref_pulse <= 1'b0;
        end
        else
        begin
            ref_pulse <= 1'b0;
            if (osc_rise)
            begin
                if (ref_cnt <= 14'h0001)
                begin
                    ref_cnt <= ref_ratio_latch;
                    ref_pulse <= 1'b1;
                end
                else
                    ref_cnt <= ref_cnt - 14'h0001;
            end
        end
    end
    // ==========================================================
    // pulse-swallow main divider
    // ==========================================================
    logic [7:0] pre_cnt;   // prescaler model count
    logic [10:0] prog_cnt; // programmable counter
    logic [6:0] swal_cnt;  // swallow counter
    logic main_pulse;
    logic modulus_run;    // modulus in force for the divide cycle under way
    logic [7:0] base_mod; // modulus of the running cycle
    logic [7:0] load_mod; // latched modulus, applied at the next reload
    assign base_mod = modulus_run ? pll_ctl_pkg::MODULUS_HIGH : pll_ctl_pkg::MODULUS_LOW;
    assign load_mod = modulus_latch ? pll_ctl_pkg::MODULUS_HIGH : pll_ctl_pkg::MODULUS_LOW;
    // prescaler divides by P+1 while swallowing, else P; total P*N+A
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            pre_cnt <= 8'h01;
            modulus_run <= 1'b0;
            prog_cnt <= pll_ctl_pkg::PROG_RATIO_RESET;
            swal_cnt <= pll_ctl_pkg::SWALLOW_RESET;
            main_pulse <= 1'b0;
        end
        else
        begin
            main_pulse <= 1'b0;
            if (pre_rise)
            begin
                if (pre_cnt <= 8'h01)
                begin
                    // one prescaler output period complete
                    if (prog_cnt <= 11'h001)
                    begin
                        prog_cnt <= prog_latch;
                        swal_cnt <= swallow_latch;
                        main_pulse <= 1'b1;
                        modulus_run <= modulus_latch;
                        pre_cnt <= (swallow_latch != 7'h00) ? load_mod + 8'h01 : load_mod;
                    end
                    else
                    begin
                        prog_cnt <= prog_cnt - 11'h001;
                        if (swal_cnt > 7'h01)
                            pre_cnt <= base_mod + 8'h01;
                        else
                            pre_cnt <= base_mod;
                        if (swal_cnt != 7'h00)
                            swal_cnt <= swal_cnt - 7'h01;
                    end
                end
                else
                    pre_cnt <= pre_cnt - 8'h01;
            end
        end
    end
    // ==========================================================
    // phase comparator (edge-triggered frequency/phase detector)
    // ==========================================================
    logic up_q, dn_q; // up: reference leads
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end
        else if ((up_q | ref_pulse) & (dn_q | main_pulse))
        begin
            up_q <= 1'b0;
            dn_q <= 1'b0;
        end
        else
        begin
            up_q <= up_q | ref_pulse;
            dn_q <= dn_q | main_pulse;
        end
    end
    // ==========================================================
    // output stage
    // ==========================================================
    logic pump_lvl, pump_drv;
    // pump level and drive per polarity table
    always_comb
    begin
        pump_drv = up_q | dn_q;
        pump_lvl = pol_s ? up_q : dn_q;
    end
    // registered outputs
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            pump_out_o <= 1'b0;
            pump_out_oe_n_o <= 1'b1;
            ref_pump_ctl_o <= 1'b0;
            main_pump_ctl_o <= 1'b0;
            main_pump_ctl_oe_n_o <= 1'b1;
            fast_lock_switch_out_o <= 1'b0;
            fast_lock_switch_out_oe_n_o <= 1'b1;
            lock_detect_out_o <= 1'b1;
            compare_monitor_out_o <= 1'b0;
            ref_divider_out_o <= 1'b0;
            main_divider_out_o <= 1'b0;
        end
        else
        begin
            pump_out_o <= pump_lvl;
            pump_out_oe_n_o <= ~pump_drv;
            // ref control high when pump goes low
            ref_pump_ctl_o <= pol_s ? dn_q : up_q;
            // open-drain main control pulls low when pump goes high
            main_pump_ctl_o <= 1'b0;
            main_pump_ctl_oe_n_o <= ~(pol_s ? up_q : dn_q);
            fast_lock_switch_out_o <= pump_lvl;
            fast_lock_switch_out_oe_n_o <= ~(strobe_s & pump_drv);
            lock_detect_out_o <= ~pump_drv;
            compare_monitor_out_o <= pol_s ? ref_pulse : main_pulse;
            ref_divider_out_o <= ref_pulse;
            main_divider_out_o <= main_pulse;
        end
    end
endmodule : pll_divider_device

/* logic/pll_serial_controller.sv */
// controller end: wishbone registers driving the three-wire programming link
`timescale 1ns/100ps
module pll_serial_controller
(
    // system
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // lock status from device (pin)
    input wire logic lock_detect_i,
    // interrupt
    output logic irq_o,
    // link
    pll_link_if.controller link
);
    // ==========================================================
    // registers
    // ==========================================================
    logic [18:0] word;        // word to send, msb first, right aligned
    logic [4:0] word_len;     // 16 or 19 by ctrl select
    logic busy;
    logic [pll_ctl_pkg::IRQ_BITS-1:0] status, mask;
    pll_ctl_pkg::ctl_state_type state;
    logic [4:0] bit_cnt;
    logic [3:0] tick;
    logic lk1, lk2, lk3; // lock sync and history
    logic go;            // start request from ctrl write
    logic done_evt;
    logic wr, rd_acc;
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
    assign rd_acc = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // ==========================================================
    // bus slave: ack one cycle after request
    // ==========================================================
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            word <= '0;
            word_len <= 5'h10;
            mask <= '0;
            go <= 1'b0;
        end
        else
        begin
            wb_ack_o <= rd_acc;
            go <= 1'b0;
            // read mux
            case (wb_adr_i)
                pll_ctl_pkg::ADDR_DATA: wb_dat_o <= {13'h0, word};
                pll_ctl_pkg::ADDR_CTRL: wb_dat_o <= {26'h0, busy, word_len};
                pll_ctl_pkg::ADDR_STATUS: wb_dat_o <= {29'h0, status};
                pll_ctl_pkg::ADDR_MASK: wb_dat_o <= {29'h0, mask};
                default: wb_dat_o <= 32'h0;
            endcase
            if (wr && wb_adr_i == pll_ctl_pkg::ADDR_DATA && !busy)
                word <= wb_dat_i[18:0];
            if (wr && wb_adr_i == pll_ctl_pkg::ADDR_MASK)
                mask <= wb_dat_i[pll_ctl_pkg::IRQ_BITS-1:0];
            // ctrl: bit0 start, bit1 main word (19 bits) else reference (16)
            if (wr && wb_adr_i == pll_ctl_pkg::ADDR_CTRL && !busy)
            begin
                word_len <= wb_dat_i[1] ? 5'h13 : 5'h10;
                go <= wb_dat_i[0];
            end
        end
    end
    // ==========================================================
    // sticky status, set wins over write-one clear
    // ==========================================================
    always_ff @(posedge clk_sys_i)
    begin
        lk1 <= lock_detect_i;
        lk2 <= lk1;
        lk3 <= lk2;
    end
    logic [pll_ctl_pkg::IRQ_BITS-1:0] evt;
    assign evt = {lk3 & ~lk2, lk2 & ~lk3, done_evt};
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            status <= '0;
        else if (wr && wb_adr_i == pll_ctl_pkg::ADDR_STATUS)
            status <= (status & ~wb_dat_i[pll_ctl_pkg::IRQ_BITS-1:0]) | evt;
        else
            status <= status | evt;
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(status & ~mask); // a set mask bit silences its event
    end
    // ==========================================================
    // link sequencer: shift msb first, then pulse strobe
    // ==========================================================
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            state <= pll_ctl_pkg::IDLE;
            bit_cnt <= '0;
            tick <= '0;
            busy <= 1'b0;
            done_evt <= 1'b0;
            link.serial_data <= 1'b0;
            link.shift_clock <= 1'b0;
            link.load_latch_strobe <= 1'b0;
        end
        else
        begin
            done_evt <= 1'b0;
            if (tick != 4'h0)
                tick <= tick - 4'h1;
            case (state)
                pll_ctl_pkg::IDLE:
                begin
                    link.load_latch_strobe <= 1'b0;
                    if (go)
                    begin
                        busy <= 1'b1;
                        bit_cnt <= word_len - 5'h01;
                        link.serial_data <= word[word_len - 5'h01];
                        tick <= pll_ctl_pkg::SCLK_HALF_CNT;
                        state <= pll_ctl_pkg::SHIFT_LOW;
                    end
                end
                pll_ctl_pkg::SHIFT_LOW:
                    if (tick == 4'h0)
                    begin
                        link.shift_clock <= 1'b1;
                        tick <= pll_ctl_pkg::SCLK_HALF_CNT;
                        state <= pll_ctl_pkg::SHIFT_HIGH;
                    end
                pll_ctl_pkg::SHIFT_HIGH:
                    if (tick == 4'h0)
                    begin
                        link.shift_clock <= 1'b0;
                        tick <= pll_ctl_pkg::SCLK_HALF_CNT;
                        if (bit_cnt == 5'h00)
                            state <= pll_ctl_pkg::LOAD;
                        else
                        begin
                            bit_cnt <= bit_cnt - 5'h01;
                            link.serial_data <= word[bit_cnt - 5'h01];
                            state <= pll_ctl_pkg::SHIFT_LOW;
                        end
                    end
                pll_ctl_pkg::LOAD:
                    // strobe waits a half period after the last fall, then stands a half period
                    if (tick == 4'h0)
                    begin
                        tick <= pll_ctl_pkg::SCLK_HALF_CNT;
                        if (!link.load_latch_strobe)
                            link.load_latch_strobe <= 1'b1;
                        else
                        begin
                            link.load_latch_strobe <= 1'b0;
                            busy <= 1'b0;
                            done_evt <= 1'b1;
                            state <= pll_ctl_pkg::IDLE;
                        end
                    end
                default: state <= pll_ctl_pkg::IDLE;
            endcase
        end
    end
    // software must keep reference ratio >= 8, N >= 16 and A < N
endmodule : pll_serial_controller

/* verification/pll_link_asserts.sv */
// checker: timing of the three-wire link between controller and device
`timescale 1ns/100ps
module pll_link_asserts
(
    // system
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // link
    input wire logic serial_data,
    input wire logic shift_clock,
    input wire logic load_latch_strobe
);
    // ==========
    // helper: shift clock rises seen since the last strobe
    logic prev_sc;
    logic [4:0] bit_cnt;
    always_ff @(posedge clk_sys_i)
    begin
        prev_sc <= shift_clock;
    end
    // cleared by reset and by every strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i || load_latch_strobe)
            bit_cnt <= 5'h00;
        else if (shift_clock && !prev_sc)
            bit_cnt <= bit_cnt + 5'h01;
    end
    // ==========
    // properties
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    sequence high_phase;
        shift_clock [*4] ##1 !shift_clock;
    endsequence
    sequence low_phase;
        !shift_clock [*4];
    endsequence
    AST_STROBE_QUIET: assert property (load_latch_strobe |-> !shift_clock)
        else $error("strobe high while shifting");
    AST_HIGH_PHASE: assert property ($rose(shift_clock) |-> high_phase)
        else $error("shift clock high phase not four cycles");
    AST_LOW_PHASE: assert property ($fell(shift_clock) |-> low_phase)
        else $error("shift clock low phase too short");
    AST_DATA_HOLD: assert property (shift_clock && $past(shift_clock) |-> $stable(serial_data))
        else $error("data moved while shift clock high");
    AST_FRAME_LEN: assert property ($rose(load_latch_strobe) |-> bit_cnt inside {5'h10, 5'h13})
        else $error("frame length neither 16 nor 19");
    AST_COUNT_CAP: assert property (bit_cnt <= 5'h13)
        else $error("more than 19 bits in a frame");
    AST_STROBE_GAP: assert property ($rose(load_latch_strobe) |-> !$past(shift_clock) && !$past(shift_clock, 2))
        else $error("strobe too close to last shift");
    AST_STROBE_END: assert property ($fell(load_latch_strobe) |-> low_phase)
        else $error("shift right after strobe");
endmodule : pll_link_asserts

/* verification/serial_pll_divider_control_tb.sv */
// testbench: controller and device joined over the three-wire link
`timescale 1ns/100ps
`define CHECK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module serial_pll_divider_control_tb;
    // ==========
    // stimulus and observed signals
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dw = 32'h0;
    logic osc = 1'b0;
    logic pre = 1'b0;
    logic pol = 1'b1;
    logic [5:0] sd = 6'h3f;
    logic [31:0] q;
    int osc_half = 32;
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int fl_bad = 0;
    int fl_on = 0;
    wire logic [31:0] dr;
    wire logic ack, irq, pump, pump_oe_n, refp, mainp, mainp_oe_n;
    wire logic fl, fl_oe_n, lock, mon, refd, maind;
    pll_link_if link();
    // ==========
    // both ends and the checker
    pll_serial_controller i_pll_serial_controller (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .lock_detect_i(lock),
        .irq_o(irq), .link(link));
    pll_divider_device i_pll_divider_device (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .link(link), .crystal_osc_input_i(osc), .prescaler_input_i(pre),
        .phase_polarity_select_i(pol), .pump_out_o(pump), .pump_out_oe_n_o(pump_oe_n),
        .ref_pump_ctl_o(refp), .main_pump_ctl_o(mainp), .main_pump_ctl_oe_n_o(mainp_oe_n),
        .fast_lock_switch_out_o(fl), .fast_lock_switch_out_oe_n_o(fl_oe_n),
        .lock_detect_out_o(lock), .compare_monitor_out_o(mon), .ref_divider_out_o(refd),
        .main_divider_out_o(maind));
    pll_link_asserts i_pll_link_asserts (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
        .serial_data(link.serial_data), .shift_clock(link.shift_clock),
        .load_latch_strobe(link.load_latch_strobe));
    // ==========
    // clocks: system 8 ns, divider inputs free running with unrelated phase
    initial
    begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #3;
        forever #(osc_half) osc = ~osc;
    end
    initial
    begin
        #1;
        forever #20 pre = ~pre;
    end
    // fast lock switch must be open once the strobe has been low a while
    always @(posedge clk_sys_i)
    begin
        sd <= {sd[4:0], link.load_latch_strobe};
        if (resetn_i && sd === 6'h00 && fl_oe_n !== 1'b1)
            fl_bad++;
        if (fl_oe_n === 1'b0)
        begin
            fl_on++;
            // a closed switch shows the driven pump level
            if (fl !== pump || pump_oe_n !== 1'b0)
                fl_bad++;
        end
    end
    // hang guard
    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            failures++;
            test_done();
        end
    end
    // ==========
    // tasks
    task automatic test_done();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    // one classic wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dw <= d;
        @(posedge clk_sys_i);
        while (ack !== 1'b1)
            @(posedge clk_sys_i);
        q = dr;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_sys_i);
    endtask : wb
    // send one word and wait for the controller to finish it
    task automatic send(input logic [31:0] word, input logic main);
        wb(1'b1, pll_ctl_pkg::ADDR_DATA, word);
        wb(1'b1, pll_ctl_pkg::ADDR_CTRL, {30'h0, main, 1'b1});
        q = 32'h20;
        while (q[5] !== 1'b0)
            wb(1'b0, pll_ctl_pkg::ADDR_CTRL, 32'h0);
        wb(1'b0, pll_ctl_pkg::ADDR_STATUS, 32'h0);
        `CHECK("frame done", 1'b1, q[0])
    endtask : send
    // clocks between main divider pulses, first two pulses skipped for reload
    task automatic period(input int ex);
        int n;
        n = 0;
        repeat (2)
        begin
            @(posedge clk_sys_i);
            while (maind !== 1'b1)
                @(posedge clk_sys_i);
        end
        do
        begin
            @(posedge clk_sys_i);
            n++;
        end
        while (maind !== 1'b1);
        `CHECK("main period", ex, n)
    endtask : period
    // compare pump outputs against the polarity table over a window
    task automatic watch(input logic p, input logic fast, input int len);
        int bad, mbad, drv;
        logic up;
        bad = 0;
        mbad = 0;
        drv = 0;
        up = (p == fast);
        pol <= p;
        repeat (8) @(posedge clk_sys_i);
        repeat (len)
        begin
            @(posedge clk_sys_i);
            if (pump_oe_n === 1'b0)
            begin
                drv++;
                if (pump !== up || refp !== !up || mainp_oe_n !== !up || lock !== 1'b0)
                    bad++;
                if (mainp !== 1'b0) // open drain only ever pulls low
                    bad++;
            end
            else if (refp !== 1'b0 || mainp_oe_n !== 1'b1)
                bad++;
            if (mon !== (p ? refd : maind))
                mbad++;
        end
        `CHECK("pump table", 0, bad)
        `CHECK("pump active", 1'b1, drv > 0)
        `CHECK("monitor select", 0, mbad)
    endtask : watch
    // ==========
    // main sequence
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        @(posedge clk_sys_i);
        `CHECK("lock at reset", 1'b1, lock)
        wb(1'b0, 4'h2, 32'h0);
        `CHECK("unmapped read", 32'h0, q)
        wb(1'b1, pll_ctl_pkg::ADDR_MASK, 32'h6);
        send({16'h0, 14'h0008, 1'b1, 1'b1}, 1'b0);
        `CHECK("irq raised", 1'b1, irq)
        wb(1'b1, pll_ctl_pkg::ADDR_STATUS, 32'h1);
        wb(1'b0, pll_ctl_pkg::ADDR_STATUS, 32'h0);
        `CHECK("done cleared", 1'b0, q[0])
        `CHECK("irq cleared", 1'b0, irq)
        wb(1'b1, pll_ctl_pkg::ADDR_MASK, 32'h7);
        send({13'h0, 11'h010, 7'h01, 1'b0}, 1'b1);
        `CHECK("irq masked", 1'b0, irq)
        wb(1'b0, pll_ctl_pkg::ADDR_CTRL, 32'h0);
        `CHECK("main length", 5'h13, q[4:0])
        period((int'(pll_ctl_pkg::MODULUS_HIGH) * 16 + 1) * 5);
        watch(1'b1, 1'b1, 2000);
        watch(1'b0, 1'b1, 2000);
        osc_half = 4000;
        // let the detector leave the old frequency relation before judging it
        repeat (24000) @(posedge clk_sys_i);
        watch(1'b1, 1'b0, 6000);
        watch(1'b0, 1'b0, 6000);
        wb(1'b0, pll_ctl_pkg::ADDR_STATUS, 32'h0);
        `CHECK("lock loss seen", 1'b1, q[2])
        send({16'h0, 14'h0008, 1'b0, 1'b1}, 1'b0);
        period((int'(pll_ctl_pkg::MODULUS_LOW) * 16 + 1) * 5);
        `CHECK("switch open", 0, fl_bad)
        `CHECK("switch closed", 1'b1, fl_on > 0)
        test_done();
    end
endmodule : serial_pll_divider_control_tb
